//--- design/sgd_pkg.sv
// constants shared by the segment driver data path and its helpers
// assumes one system clock; all pins are sampled as synchronous inputs
package sgd_pkg;

   // ----------
   // geometry
   // ----------
   localparam int SGD_NUM_SEG   = 120;
   localparam int SGD_PAR_WIDTH = 4;

   // ----------
   // output level codes, two bits per segment
   // ----------
   localparam logic [1:0] SGD_LVL_GND    = 2'h0;
   localparam logic [1:0] SGD_LVL_THIRD  = 2'h1;
   localparam logic [1:0] SGD_LVL_SECOND = 2'h2;
   localparam logic [1:0] SGD_LVL_TOP    = 2'h3;

   // ----------
   // register map, byte addresses
   // ----------
   localparam logic [7:0] SGD_OFS_CTRL   = 8'h00;
   localparam logic [7:0] SGD_OFS_STATUS = 8'h04;
   localparam logic [7:0] SGD_OFS_LATCH0 = 8'h08;
   localparam logic [7:0] SGD_OFS_LATCH1 = 8'h0C;
   localparam logic [7:0] SGD_OFS_LATCH2 = 8'h10;
   localparam logic [7:0] SGD_OFS_LATCH3 = 8'h14;

   // ----------
   // field positions and reset values
   // ----------
   localparam int SGD_CTRL_BLANK_BIT  = 0;
   localparam int SGD_STAT_SEL_BIT    = 0;
   localparam int SGD_STAT_ARMED_BIT  = 1;
   localparam int SGD_STAT_EO_BIT     = 2;
   localparam int SGD_STAT_DIR_BIT    = 3;
   localparam int SGD_STAT_WIDTH_BIT  = 4;
   localparam int SGD_STAT_CNT_LSB    = 8;
   localparam logic SGD_CTRL_BLANK_RST = 1'h0;

   // ----------
   // bus answers
   // ----------
   localparam logic [1:0] SGD_RESP_OKAY   = 2'h0;
   localparam logic [1:0] SGD_RESP_SLVERR = 2'h2;

endpackage

//--- design/sgd_fall_detect.sv
// falling edge detector for a pin sampled on the system clock
// assumes the pin is already synchronous to mclk_in
module sgd_fall_detect
   import sgd_pkg::*;
(
   input  wire logic mclk_in,
   input  wire logic resetn_in,
   input  wire logic level_in,
   output logic      fall_out
);

   typedef struct packed {
      logic prev;
   } sgd_fd_state_t;

   sgd_fd_state_t st_ff;
   sgd_fd_state_t nxt_st;

   always_comb begin
      nxt_st      = st_ff;
      nxt_st.prev = level_in;
   end

   // reset to low so a pin held low at release gives no false edge
   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign fall_out = st_ff.prev & ~level_in;

endmodule

//--- design/sgd_axil_slave.sv
// axi4-lite slave front end: handshakes, one write and one read at a time
// assumes the owner decodes addresses and supplies read data combinationally
module sgd_axil_slave
   import sgd_pkg::*;
#(
   parameter int ADDR_W = 8
)(
   input  wire logic              mclk_in,
   input  wire logic              resetn_in,
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   output logic                   wr_en_out,
   output logic [ADDR_W-1:0]      wr_addr_out,
   output logic [31:0]            wr_data_out,
   output logic [3:0]             wr_strb_out,
   input  wire logic              wr_err_in,
   output logic [ADDR_W-1:0]      rd_addr_out,
   input  wire logic [31:0]       rd_data_in,
   input  wire logic              rd_err_in
);

   typedef struct packed {
      logic              aw_full;
      logic [ADDR_W-1:0] aw_addr;
      logic              w_full;
      logic [31:0]       w_data;
      logic [3:0]        w_strb;
      logic              bvalid;
      logic [1:0]        bresp;
      logic              rvalid;
      logic [31:0]       rdata;
      logic [1:0]        rresp;
   } sgd_ax_state_t;

   sgd_ax_state_t st_ff;
   sgd_ax_state_t nxt_st;
   logic          do_write;

   // ----------
   // handshakes
   // ----------
   assign s_axi_awready = ~st_ff.aw_full & ~st_ff.bvalid;
   assign s_axi_wready  = ~st_ff.w_full & ~st_ff.bvalid;
   assign s_axi_arready = ~st_ff.rvalid;
   assign do_write      = st_ff.aw_full & st_ff.w_full & ~st_ff.bvalid;

   assign wr_en_out   = do_write;
   assign wr_addr_out = st_ff.aw_addr;
   assign wr_data_out = st_ff.w_data;
   assign wr_strb_out = st_ff.w_strb;
   assign rd_addr_out = s_axi_araddr;

   always_comb begin
      nxt_st = st_ff;
      if (s_axi_awvalid && s_axi_awready) begin
         nxt_st.aw_full = 1'b1;
         nxt_st.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         nxt_st.w_full = 1'b1;
         nxt_st.w_data = s_axi_wdata;
         nxt_st.w_strb = s_axi_wstrb;
      end
      if (do_write) begin
         nxt_st.aw_full = 1'b0;
         nxt_st.w_full  = 1'b0;
         nxt_st.bvalid  = 1'b1;
         nxt_st.bresp   = wr_err_in ? SGD_RESP_SLVERR : SGD_RESP_OKAY;
      end
      if (st_ff.bvalid && s_axi_bready) begin
         nxt_st.bvalid = 1'b0;
      end
      // read data captured at address acceptance, held until taken
      if (s_axi_arvalid && s_axi_arready) begin
         nxt_st.rvalid = 1'b1;
         nxt_st.rdata  = rd_err_in ? 32'h0000_0000 : rd_data_in;
         nxt_st.rresp  = rd_err_in ? SGD_RESP_SLVERR : SGD_RESP_OKAY;
      end else if (st_ff.rvalid && s_axi_rready) begin
         nxt_st.rvalid = 1'b0;
      end
   end

   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign s_axi_bvalid = st_ff.bvalid;
   assign s_axi_bresp  = st_ff.bresp;
   assign s_axi_rvalid = st_ff.rvalid;
   assign s_axi_rdata  = st_ff.rdata;
   assign s_axi_rresp  = st_ff.rresp;

endmodule

//--- design/sgd_data_path.sv
// segment driver data path: row shifter, cascade enable chain, output latches
// and per-segment level select, with an axi4-lite window for status and control
// assumes shift_clk and line_latch are slow against mclk_in and synchronous to it
//
// Operation
// [R01] direction select low fills positions 120 down to 1, high fills 1 up to 120.
// [R02] direction select low makes chain pin a the enable output and b the input, high swaps.
// [R03] the enable output rests low and is high for one shift clock after 120 bits are taken.
// [R04] after a line latch the device selects itself on a high enable input and deselects after 120 bits.
// [R05] serial width takes one bit per shift clock from the top data input only, 120 clocks a row.
// [R06] parallel width takes four bits per shift clock, so a row needs 30 clocks.
// [R07] in parallel mode inputs 3..0 map to 120..117 stepping down, or 1..4 stepping up.
// [R08] display data is sampled on the falling edge of the shift clock.
// [R09] the falling edge of line latch copies the shifted row into the output latches.
// [R10] when not blanked each output level follows phase and latched bit.
// [R11] while blank_n is low every segment output is at ground.
// [R12] the system holds blank_n low over panel supply power-up and power-down.
// [R13] cascaded drivers chain enable out to enable in, and the first is started after line latch.
// [R14] while deselected, shift clock edges are ignored and stored row data stays unchanged.
//
// Implementation choices: the placing of the registers and the AXI4-Lite register port.
module sgd_data_path
   import sgd_pkg::*;
#(
   parameter int NUM_SEG = SGD_NUM_SEG,
   parameter int ADDR_W  = 8
)(
   input  wire logic              mclk_in,
   input  wire logic              resetn_in,
   input  wire logic              shift_clk_in,
   input  wire logic              line_latch_in,
   input  wire logic [3:0]        pixel_in,
   input  wire logic              shift_dir_sel_in,
   input  wire logic              input_width_sel_in,
   input  wire logic              ac_phase_in,
   input  wire logic              blank_n_in,
   input  wire logic              chain_io_a_in,
   output logic                   chain_io_a_out,
   output logic                   chain_io_a_oe_n_out,
   input  wire logic              chain_io_b_in,
   output logic                   chain_io_b_out,
   output logic                   chain_io_b_oe_n_out,
   output logic [2*NUM_SEG-1:0]   seg_out,
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready
);

   localparam int CNT_W = $clog2(NUM_SEG + 1);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [NUM_SEG-1:0]   row;
      logic [NUM_SEG-1:0]   latch;
      logic [2*NUM_SEG-1:0] seg;
      logic [CNT_W-1:0]     count;
      logic                 selected;
      logic                 armed;
      logic                 enable_out;
      logic                 soft_blank;
   } sgd_state_t;

   sgd_state_t st_ff;
   sgd_state_t nxt_st;

   logic              shift_fall;
   logic              latch_fall;
   logic              enable_in;
   logic              take;
   logic [CNT_W-1:0]  step;
   logic [CNT_W:0]    next_count;
   logic              wr_en;
   logic [ADDR_W-1:0] wr_addr;
   logic [31:0]       wr_data;
   logic [3:0]        wr_strb;
   logic              wr_err;
   logic [ADDR_W-1:0] rd_addr;
   logic [31:0]       rd_data;
   logic              rd_err;
   logic [127:0]      latch_wide;
   logic              blanked;

   // ----------------------------------------------------------------
   // edge detection of the controller strobes
   // ----------------------------------------------------------------
   sgd_fall_detect u_shift_fall (
      .mclk_in   (mclk_in),
      .resetn_in (resetn_in),
      .level_in  (shift_clk_in),
      .fall_out  (shift_fall)     // [R08]
   );

   sgd_fall_detect u_latch_fall (
      .mclk_in   (mclk_in),
      .resetn_in (resetn_in),
      .level_in  (line_latch_in),
      .fall_out  (latch_fall)     // [R09]
   );

   // ----------------------------------------------------------------
   // cascade chain pins
   // ----------------------------------------------------------------
   assign enable_in           = shift_dir_sel_in ? chain_io_a_in : chain_io_b_in;   // [R02]
   assign chain_io_a_out      = shift_dir_sel_in ? 1'b0 : st_ff.enable_out;        // [R02]
   assign chain_io_b_out      = shift_dir_sel_in ? st_ff.enable_out : 1'b0;        // [R02]
   assign chain_io_a_oe_n_out = shift_dir_sel_in;                                  // [R02]
   assign chain_io_b_oe_n_out = ~shift_dir_sel_in;                                 // [R02]

   // ----------------------------------------------------------------
   // row shifter and selection
   // ----------------------------------------------------------------
   // a deselected driver never touches its row, so a chain of drivers can
   // share the data pins without disturbing each other
   assign take = shift_fall & (st_ff.selected | (st_ff.armed & enable_in));        // [R04] [R14]
   assign step = input_width_sel_in ? CNT_W'(SGD_PAR_WIDTH) : CNT_W'(1);          // [R05] [R06]
   assign next_count = {1'b0, st_ff.count} + {1'b0, step};
   assign blanked = ~blank_n_in | st_ff.soft_blank;

   always_comb begin
      int base;
      int pos;
      nxt_st = st_ff;
      base   = int'(st_ff.count);
      pos    = 0;

      if (take) begin
         if (input_width_sel_in) begin
            for (int j = 0; j < SGD_PAR_WIDTH; j++) begin
               // input 3 lands first in fill order
               pos = shift_dir_sel_in ? base + j : NUM_SEG - 1 - base - j;         // [R07] [R01]
               if (pos >= 0 && pos < NUM_SEG) begin
                  nxt_st.row[pos] = pixel_in[SGD_PAR_WIDTH-1-j];                   // [R06]
               end
            end
         end else begin
            pos = shift_dir_sel_in ? base : NUM_SEG - 1 - base;                    // [R01]
            if (pos >= 0 && pos < NUM_SEG) begin
               nxt_st.row[pos] = pixel_in[3];                                      // [R05]
            end
         end
         nxt_st.selected = 1'b1;                                                   // [R04]
         nxt_st.armed    = 1'b0;
         if (int'(next_count) >= NUM_SEG) begin
            nxt_st.selected   = 1'b0;                                              // [R04]
            nxt_st.count      = '0;
            nxt_st.enable_out = 1'b1;                                              // [R03]
         end else begin
            nxt_st.count      = next_count[CNT_W-1:0];
            nxt_st.enable_out = 1'b0;
         end
      end else if (shift_fall) begin
         nxt_st.enable_out = 1'b0;                                                 // [R03]
      end

      // line latch ends any row in flight and rearms the selection
      if (latch_fall) begin
         nxt_st.latch      = st_ff.row;                                            // [R09]
         nxt_st.armed      = 1'b1;                                                 // [R04]
         nxt_st.selected   = 1'b0;
         nxt_st.count      = '0;
         nxt_st.enable_out = 1'b0;                                                 // [R03]
      end

      // ---------------------------------------------------------------
      // level select, one register stage so outputs come from flops
      // ---------------------------------------------------------------
      for (int i = 0; i < NUM_SEG; i++) begin
         if (blanked) begin
            nxt_st.seg[2*i +: 2] = SGD_LVL_GND;                                    // [R11]
         end else if (!ac_phase_in) begin
            nxt_st.seg[2*i +: 2] = st_ff.latch[i] ? SGD_LVL_TOP : SGD_LVL_SECOND;  // [R10]
         end else begin
            nxt_st.seg[2*i +: 2] = st_ff.latch[i] ? SGD_LVL_GND : SGD_LVL_THIRD;   // [R10]
         end
      end

      // ---------------------------------------------------------------
      // software control
      // ---------------------------------------------------------------
      if (wr_en && wr_addr == ADDR_W'(SGD_OFS_CTRL) && wr_strb[0]) begin
         nxt_st.soft_blank = wr_data[SGD_CTRL_BLANK_BIT];
      end
   end

   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         st_ff            <= '0;
         st_ff.soft_blank <= SGD_CTRL_BLANK_RST;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign seg_out = st_ff.seg;

   // ----------------------------------------------------------------
   // register access
   // ----------------------------------------------------------------
   assign latch_wide = 128'(st_ff.latch);

   always_comb begin
      rd_data = 32'h0000_0000;
      rd_err  = 1'b0;
      unique case (rd_addr)
         ADDR_W'(SGD_OFS_CTRL): begin
            rd_data[SGD_CTRL_BLANK_BIT] = st_ff.soft_blank;
         end
         ADDR_W'(SGD_OFS_STATUS): begin
            rd_data[SGD_STAT_SEL_BIT]   = st_ff.selected;
            rd_data[SGD_STAT_ARMED_BIT] = st_ff.armed;
            rd_data[SGD_STAT_EO_BIT]    = st_ff.enable_out;
            rd_data[SGD_STAT_DIR_BIT]   = shift_dir_sel_in;
            rd_data[SGD_STAT_WIDTH_BIT] = input_width_sel_in;
            rd_data[SGD_STAT_CNT_LSB +: CNT_W] = st_ff.count;
         end
         ADDR_W'(SGD_OFS_LATCH0): rd_data = latch_wide[31:0];
         ADDR_W'(SGD_OFS_LATCH1): rd_data = latch_wide[63:32];
         ADDR_W'(SGD_OFS_LATCH2): rd_data = latch_wide[95:64];
         ADDR_W'(SGD_OFS_LATCH3): rd_data = latch_wide[127:96];
         default: rd_err = 1'b1;
      endcase
   end

   // read-only words accept writes silently; only holes answer an error
   always_comb begin
      wr_err = 1'b1;
      unique case (wr_addr)
         ADDR_W'(SGD_OFS_CTRL),
         ADDR_W'(SGD_OFS_STATUS),
         ADDR_W'(SGD_OFS_LATCH0),
         ADDR_W'(SGD_OFS_LATCH1),
         ADDR_W'(SGD_OFS_LATCH2),
         ADDR_W'(SGD_OFS_LATCH3): wr_err = 1'b0;
         default: wr_err = 1'b1;
      endcase
   end

   sgd_axil_slave #(
      .ADDR_W (ADDR_W)
   ) u_axil (
      .mclk_in       (mclk_in),
      .resetn_in     (resetn_in),
      .s_axi_awaddr  (s_axi_awaddr),
      .s_axi_awvalid (s_axi_awvalid),
      .s_axi_awready (s_axi_awready),
      .s_axi_wdata   (s_axi_wdata),
      .s_axi_wstrb   (s_axi_wstrb),
      .s_axi_wvalid  (s_axi_wvalid),
      .s_axi_wready  (s_axi_wready),
      .s_axi_bresp   (s_axi_bresp),
      .s_axi_bvalid  (s_axi_bvalid),
      .s_axi_bready  (s_axi_bready),
      .s_axi_araddr  (s_axi_araddr),
      .s_axi_arvalid (s_axi_arvalid),
      .s_axi_arready (s_axi_arready),
      .s_axi_rdata   (s_axi_rdata),
      .s_axi_rresp   (s_axi_rresp),
      .s_axi_rvalid  (s_axi_rvalid),
      .s_axi_rready  (s_axi_rready),
      .wr_en_out     (wr_en),
      .wr_addr_out   (wr_addr),
      .wr_data_out   (wr_data),
      .wr_strb_out   (wr_strb),
      .wr_err_in     (wr_err),
      .rd_addr_out   (rd_addr),
      .rd_data_in    (rd_data),
      .rd_err_in     (rd_err)
   );

endmodule

//--- tb/sgd_ctrl_model.sv
// display controller model: line latch, cascade start and shift strobes
// assumes the bench holds dir and width steady while send_row runs
module sgd_ctrl_model
   import sgd_pkg::*;
(
   input  wire logic  mclk_in,
   output logic       shift_clk_out,
   output logic       line_latch_out,
   output logic [3:0] pixel_out,
   output logic       enable_out
);
   timeunit 1ns;
   timeprecision 1ns;
   // ----------
   // row sender
   // ----------
   initial begin
      shift_clk_out  = 1'h0;
      line_latch_out = 1'h0;
      pixel_out      = 4'h5;
      enable_out     = 1'h0;
   end
   // takes past a full row send ones, so a device that keeps taking is seen
   task automatic send_row(input logic [119:0] row, input int takes, input logic par,
                           input logic dir, input int gap);
      int         w;
      int         idx;
      logic [3:0] pix;
      w = par ? 4 : 1;
      @(posedge mclk_in);
      line_latch_out <= 1'h1;
      repeat (2) @(posedge mclk_in);
      line_latch_out <= 1'h0;
      @(posedge mclk_in);
      enable_out <= 1'h1;
      for (int k = 0; k < takes; k++) begin
         pix = par ? 4'h0 : 4'h5;
         for (int j = 0; j < w; j++) begin
            idx = dir ? k * w + j : 119 - k * w - j;
            pix[3 - j] = (k * w < 120) ? row[idx] : 1'h1;
         end
         pixel_out     <= pix;
         shift_clk_out <= 1'h1;
         repeat (1 + gap) @(posedge mclk_in);
         shift_clk_out <= 1'h0;
         @(posedge mclk_in);
         // hold time over: flip the data so a late sample shows
         pixel_out <= par ? ~pix : {~pix[3], pix[2:0]};
         repeat (1 + gap) @(posedge mclk_in);
      end
      @(posedge mclk_in);
      enable_out <= 1'h0;
   endtask
endmodule

//--- tb/sgd_data_path_monitor.sv
// pin-level checker for the segment driver data path
// assumes it is bound to sgd_data_path and sees only its ports
module sgd_data_path_monitor
   import sgd_pkg::*;
#(
   parameter int NUM_SEG = SGD_NUM_SEG
)(
   input wire logic               mclk_in,
   input wire logic               resetn_in,
   input wire logic               shift_clk_in,
   input wire logic               line_latch_in,
   input wire logic               shift_dir_sel_in,
   input wire logic               ac_phase_in,
   input wire logic               blank_n_in,
   input wire logic               chain_io_a_out,
   input wire logic               chain_io_a_oe_n_out,
   input wire logic               chain_io_b_out,
   input wire logic               chain_io_b_oe_n_out,
   input wire logic [2*NUM_SEG-1:0] seg_out
);
   timeunit 1ns;
   timeprecision 1ns;
   // ----------
   // properties
   // ----------
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (!resetn_in);
   logic eo;
   assign eo = shift_dir_sel_in ? chain_io_b_out : chain_io_a_out;
   a_a_dir_oe: assert property (chain_io_a_oe_n_out == shift_dir_sel_in)
      else $error("chain pin a direction wrong");
   a_b_dir_oe: assert property (chain_io_b_oe_n_out == !shift_dir_sel_in)
      else $error("chain pin b direction wrong");
   a_a_input_quiet: assert property (shift_dir_sel_in |-> !chain_io_a_out)
      else $error("chain pin a driven while input");
   a_b_input_quiet: assert property (!shift_dir_sel_in |-> !chain_io_b_out)
      else $error("chain pin b driven while input");
   a_pulse_hold: assert property (eo && !$fell(shift_clk_in) && !$fell(line_latch_in)
      |=> eo)
      else $error("enable pulse shorter than a shift cycle");
   a_pulse_drop: assert property (eo && $fell(shift_clk_in) |=> !eo)
      else $error("enable pulse longer than a shift cycle");
   a_blank_ground: assert property (!blank_n_in |=> seg_out == '0)
      else $error("segments not grounded while blanked");
   a_phase_high_low: assert property (blank_n_in && ac_phase_in
      |=> (seg_out & {NUM_SEG{2'h2}}) == '0)
      else $error("high bias level with phase high");
endmodule

bind sgd_data_path sgd_data_path_monitor #(.NUM_SEG(NUM_SEG)) u_sgd_data_path_monitor (
   .mclk_in, .resetn_in, .shift_clk_in, .line_latch_in, .shift_dir_sel_in, .ac_phase_in,
   .blank_n_in, .chain_io_a_out, .chain_io_a_oe_n_out, .chain_io_b_out,
   .chain_io_b_oe_n_out, .seg_out);

//--- tb/sgd_data_path_tb.sv
// self-checking bench for the segment driver data path
// assumes the controller model drives strobes; bench speaks axi4-lite
module sgd_data_path_tb
   import sgd_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct packed {
      logic         par;
      logic         dir;
      logic         ph;
      logic [7:0]   takes;
      logic [119:0] pat;
   } sgd_case_t;
   logic         mclk_in;
   logic         resetn_in = 1'h0, shift_dir_sel_in = 1'h0, input_width_sel_in = 1'h0;
   logic         ac_phase_in = 1'h0, blank_n_in = 1'h0, shift_clk_in, line_latch_in;
   logic         enable_w, eo_q = 1'h0;
   logic [3:0]   pixel_in, s_axi_wstrb = 4'hF;
   logic         chain_io_a_in, chain_io_a_out, chain_io_a_oe_n_out;
   logic         chain_io_b_in, chain_io_b_out, chain_io_b_oe_n_out;
   logic [239:0] seg_out, e;
   logic [7:0]   s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0]  s_axi_wdata = 32'h0, s_axi_rdata, q;
   logic         s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic         s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
   logic         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]   s_axi_bresp, s_axi_rresp, r;
   int           bad_count = 0, samples_checked = 0, eo_rises = 0, n;
   sgd_case_t    tab [4] = '{'{1'h0, 1'h0, 1'h0, 8'h7B, {15{8'h1D}}},
                             '{1'h0, 1'h1, 1'h1, 8'h78, {15{8'hC5}}},
                             '{1'h1, 1'h0, 1'h0, 8'h20, {15{8'h96}}},
                             '{1'h1, 1'h1, 1'h1, 8'h1E, {15{8'h2E}}}};
   // ----------
   // wiring
   // ----------
   // the input end of each chain pin sees the controller, the output end the device
   assign chain_io_a_in = chain_io_a_oe_n_out ? enable_w : chain_io_a_out;
   assign chain_io_b_in = chain_io_b_oe_n_out ? enable_w : chain_io_b_out;
   sgd_ctrl_model u_sgd_ctrl_model (.mclk_in, .shift_clk_out(shift_clk_in),
      .line_latch_out(line_latch_in), .pixel_out(pixel_in), .enable_out(enable_w));
   sgd_data_path u_sgd_data_path (.mclk_in, .resetn_in, .shift_clk_in, .line_latch_in,
      .pixel_in, .shift_dir_sel_in, .input_width_sel_in, .ac_phase_in, .blank_n_in,
      .chain_io_a_in, .chain_io_a_out, .chain_io_a_oe_n_out, .chain_io_b_in,
      .chain_io_b_out, .chain_io_b_oe_n_out, .seg_out, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
   initial begin
      mclk_in = 1'h0;
      forever #50 mclk_in = ~mclk_in;
   end
   always @(posedge mclk_in) begin
      eo_q <= shift_dir_sel_in ? chain_io_b_out : chain_io_a_out;
      if ((shift_dir_sel_in ? chain_io_b_out : chain_io_a_out) === 1'h1 && !eo_q) eo_rises++;
   end
   // ----------
   // tasks
   // ----------
   task automatic axi(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rq, output logic [1:0] rr);
      @(posedge mclk_in);
      if (wr) begin
         s_axi_awaddr  <= a;
         s_axi_wdata   <= d;
         s_axi_awvalid <= 1'h1;
         s_axi_wvalid  <= 1'h1;
         s_axi_bready  <= 1'h1;
         do begin
            @(posedge mclk_in);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
         end while (s_axi_bvalid !== 1'h1);
         rr = s_axi_bresp;
         s_axi_bready <= 1'h0;
      end else begin
         s_axi_araddr  <= a;
         s_axi_arvalid <= 1'h1;
         s_axi_rready  <= 1'h1;
         do begin
            @(posedge mclk_in);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
         end while (s_axi_rvalid !== 1'h1);
         rq = s_axi_rdata;
         rr = s_axi_rresp;
         s_axi_rready <= 1'h0;
      end
   endtask
   task automatic chk(input logic [239:0] got, input logic [239:0] exp);
      samples_checked++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // ----------
   // sequence
   // ----------
   initial begin
      repeat (16) @(posedge mclk_in);
      resetn_in <= 1'h1;
      @(posedge mclk_in);
      chk(seg_out, '0);
      chk({chain_io_a_out, chain_io_b_out, chain_io_a_oe_n_out, chain_io_b_oe_n_out}, 4'h1);
      repeat (4) @(posedge mclk_in);
      blank_n_in <= 1'h1;
      foreach (tab[i]) begin
         @(posedge mclk_in);
         shift_dir_sel_in   <= tab[i].dir;
         input_width_sel_in <= tab[i].par;
         ac_phase_in        <= tab[i].ph;
         n = eo_rises;
         u_sgd_ctrl_model.send_row(tab[i].pat, tab[i].takes, tab[i].par, tab[i].dir, i % 2);
         repeat (2) @(posedge mclk_in);
         chk(eo_rises - n, 1);
         u_sgd_ctrl_model.send_row('0, 0, tab[i].par, tab[i].dir, 0);
         repeat (3) @(posedge mclk_in);
         for (int p = 0; p < 120; p++) begin
            e[2*p +: 2] = tab[i].ph ? (tab[i].pat[p] ? SGD_LVL_GND : SGD_LVL_THIRD)
                                    : (tab[i].pat[p] ? SGD_LVL_TOP : SGD_LVL_SECOND);
         end
         chk(seg_out, e);
      end
      axi(1'h0, SGD_OFS_STATUS, 32'h0, q, r);
      chk(q[4:0], 5'h1A);
      axi(1'h0, SGD_OFS_LATCH0, 32'h0, q, r);
      chk(q, tab[3].pat[31:0]);
      axi(1'h0, 8'h40, 32'h0, q, r);
      chk(r, SGD_RESP_SLVERR);
      axi(1'h1, SGD_OFS_CTRL, 32'h1, q, r);
      chk(r, SGD_RESP_OKAY);
      repeat (2) @(posedge mclk_in);
      chk(seg_out, '0);
      axi(1'h1, SGD_OFS_CTRL, 32'h0, q, r);
      repeat (2) @(posedge mclk_in);
      chk(seg_out, e);
      blank_n_in <= 1'h0;
      repeat (2) @(posedge mclk_in);
      chk(seg_out, '0);
      summarize();
   end
   initial begin
      repeat (20000) @(posedge mclk_in);
      bad_count++;
      summarize();
   end
endmodule
